// >>> rtl/deirq_pkg.sv
// Purpose: shared constants for the error interrupt unit
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: register indices are scaled by four to form byte addresses
package deirq_pkg;
   localparam int unsigned deirq_addr_w = 12;
   // register indices, byte address is index times four
   localparam logic [7:0] deirq_idx_ctrl = 8'he0;
   localparam logic [7:0] deirq_idx_mask = 8'he1;
   localparam logic [7:0] deirq_idx_status = 8'he5;
   localparam logic [deirq_addr_w-1:0] deirq_addr_ctrl = {2'h0, deirq_idx_ctrl, 2'h0};
   localparam logic [deirq_addr_w-1:0] deirq_addr_mask = {2'h0, deirq_idx_mask, 2'h0};
   localparam logic [deirq_addr_w-1:0] deirq_addr_status = {2'h0, deirq_idx_status, 2'h0};
   // field positions
   localparam int unsigned deirq_bit_out_en = 0;
   localparam int unsigned deirq_bit_sync = 7;
   localparam int unsigned deirq_bit_checksum = 6;
   localparam int unsigned deirq_bit_uncorr = 5;
   localparam int unsigned deirq_bit_corr = 4;
   localparam int unsigned deirq_bit_llp = 3;
   localparam int unsigned deirq_bit_leader = 2;
   localparam int unsigned deirq_bit_unlock = 0;
   localparam logic [7:0] deirq_src_bits = 8'hfd;
   // values after reset
   localparam logic [7:0] deirq_ctrl_rst = 8'h00;
   localparam logic [7:0] deirq_mask_rst = 8'h00;
   localparam logic [7:0] deirq_status_rst = 8'h01;
   localparam logic [1:0] deirq_sync_rst = 2'h0;
   // lock indication assumed locked before the first sample
   localparam logic deirq_lock_rst = 1'b1;
endpackage

// >>> rtl/deirq_sync2.sv
// Purpose: two flip-flop synchroniser for one level
// Assumes: input asynchronous to pclk
// Notes: first stage feeds the second stage only; stages reset to the locked level so no false unlock
`timescale 1ns/1ps
module deirq_sync2
   import deirq_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // level
   input wire logic async_in,
   output logic sync_out
);
   logic [1:0] stage;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage <= {2{deirq_lock_rst}};
      end else begin
         stage <= {stage[0], async_in};
      end
   end

   assign sync_out = stage[1];
endmodule

// >>> rtl/deirq_fall_det.sv
// Purpose: one-cycle pulse on a falling level
// Assumes: input already synchronised to pclk
// Notes: history resets to the locked value so reset gives no pulse
`timescale 1ns/1ps
module deirq_fall_det
   import deirq_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // level and pulse
   input wire logic level,
   output logic fell
);
   logic prev;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= deirq_lock_rst;
      end else begin
         prev <= level;
      end
   end

   assign fell = prev & ~level;
endmodule

// >>> rtl/deirq_top.sv
// Purpose: sticky error flags, masks and interrupt pin drive over apb
// Assumes: error strobes are single-cycle pulses on pclk; pll lock is asynchronous
// Notes: interrupt pin is a two-signal tri-state, oe low means driven
// Behaviour
// - output enable clear leaves interrupt pin floating; reset state
// - enable set: drive pin high when any unmasked flag set
// - unexpected sync packet sets status bit 7
// - checksum mismatch sets status bit 6
// - uncorrectable header error sets status bit 5
// - corrected single header error sets status bit 4
// - any low-level protocol error sets status bit 3
// - leader sequence bit error sets status bit 2
// - lock-to-unlock transition sets bit 0; bit 0 resets to one
// - flags stay set until software writes one to them
// - mask register holds one enable per source at status positions
// - enables and output enable reset to zero and are read/write
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module deirq_top
   import deirq_pkg::*;
(
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [deirq_addr_w-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // packet processor error strobes
   input wire logic sync_fault_evt,
   input wire logic checksum_fault_evt,
   input wire logic uncorrectable_header_evt,
   input wire logic corrected_header_evt,
   input wire logic low_level_protocol_evt,
   input wire logic leader_bit_fault_evt,
   // pll lock indication, asynchronous
   input wire logic pll_locked,
   // interrupt pin
   output logic irq_out,
   output logic irq_oe_n
);
   typedef enum logic [1:0] {
      deirq_idle_s = 2'h0,
      deirq_access_s = 2'h1,
      deirq_done_s = 2'h3
   } deirq_state_t;

   deirq_state_t state;
   deirq_state_t next_state;
   logic [7:0] irq_output_control;
   logic [7:0] irq_source_mask;
   logic [7:0] error_status_flags;
   logic [7:0] next_flags;
   logic [7:0] set_evt;
   logic [7:0] clr_mask;
   logic lock_sync;
   logic unlock_evt;
   logic wr_ctrl;
   logic wr_mask;
   logic wr_status;
   logic take;
   logic mapped;
   logic [31:0] rd_mux;

   function automatic logic addr_hit(input logic [deirq_addr_w-1:0] a, input logic [deirq_addr_w-1:0] r);
      addr_hit = (a == r);
   endfunction

   deirq_sync2 u_lock_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pll_locked),
      .sync_out(lock_sync)
   );

   deirq_fall_det u_unlock (
      .pclk(pclk),
      .presetn(presetn),
      .level(lock_sync),
      .fell(unlock_evt)
   );

   // apb: access phase answered in its first cycle, no wait states
   always_comb begin
      next_state = state;
      case (state)
         deirq_idle_s: begin
            if (psel && !penable) begin
               next_state = deirq_access_s;
            end
         end
         deirq_access_s: begin
            next_state = deirq_done_s;
         end
         deirq_done_s: begin
            // a setup straight after the previous access is accepted here
            if (psel && !penable) begin
               next_state = deirq_access_s;
            end else begin
               next_state = deirq_idle_s;
            end
         end
         default: begin
            next_state = deirq_idle_s;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= deirq_idle_s;
      end else begin
         state <= next_state;
      end
   end

   // take is the cycle where pready is high together with penable
   assign take = psel && penable && pready;
   assign mapped = addr_hit(paddr, deirq_addr_ctrl) || addr_hit(paddr, deirq_addr_mask) ||
      addr_hit(paddr, deirq_addr_status);
   assign wr_ctrl = take && pwrite && pstrb[0] && addr_hit(paddr, deirq_addr_ctrl);
   assign wr_mask = take && pwrite && pstrb[0] && addr_hit(paddr, deirq_addr_mask);
   assign wr_status = take && pwrite && pstrb[0] && addr_hit(paddr, deirq_addr_status);

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_hit(paddr, deirq_addr_ctrl)) begin
         rd_mux = {24'h00_0000, irq_output_control};
      end else if (addr_hit(paddr, deirq_addr_mask)) begin
         rd_mux = {24'h00_0000, irq_source_mask};
      end else if (addr_hit(paddr, deirq_addr_status)) begin
         rd_mux = {24'h00_0000, error_status_flags};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= (next_state == deirq_access_s);
         pslverr <= (next_state == deirq_access_s) && !mapped;
         if (next_state == deirq_access_s && !pwrite) begin
            prdata <= rd_mux;
         end else if (next_state != deirq_access_s) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // output enable, bit 0 only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_output_control <= deirq_ctrl_rst;
      end else if (wr_ctrl) begin
         irq_output_control <= {7'h00, pwdata[deirq_bit_out_en]};
      end
   end

   // one mask bit per source, bit 1 unused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_source_mask <= deirq_mask_rst;
      end else if (wr_mask) begin
         irq_source_mask <= pwdata[7:0] & deirq_src_bits;
      end
   end

   always_comb begin
      set_evt = 8'h00;
      set_evt[deirq_bit_sync] = sync_fault_evt;
      set_evt[deirq_bit_checksum] = checksum_fault_evt;
      set_evt[deirq_bit_uncorr] = uncorrectable_header_evt;
      set_evt[deirq_bit_corr] = corrected_header_evt;
      set_evt[deirq_bit_llp] = low_level_protocol_evt;
      set_evt[deirq_bit_leader] = leader_bit_fault_evt;
      set_evt[deirq_bit_unlock] = unlock_evt;
   end

   // write-one-to-clear; a set in the same cycle wins
   assign clr_mask = wr_status ? (pwdata[7:0] & deirq_src_bits) : 8'h00;
   assign next_flags = (error_status_flags & ~clr_mask) | set_evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         error_status_flags <= deirq_status_rst;
      end else begin
         error_status_flags <= next_flags;
      end
   end

   // pin follows the registered flags one cycle later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_out <= 1'b0;
         irq_oe_n <= 1'b1;
      end else begin
         irq_oe_n <= !irq_output_control[deirq_bit_out_en];
         irq_out <= irq_output_control[deirq_bit_out_en] &&
            |(error_status_flags & irq_source_mask);
      end
   end
endmodule

// >>> verification/deirq_monitor.sv
// Purpose: port checks of the error interrupt unit
// Assumes: no wait states per apb access
// Notes: bound into deirq_top
`timescale 1ns/1ps
module deirq_monitor
   import deirq_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [deirq_addr_w-1:0] paddr,
   input wire logic [31:0] prdata,
   // events and pin
   input wire logic sync_fault_evt,
   input wire logic checksum_fault_evt,
   input wire logic uncorrectable_header_evt,
   input wire logic corrected_header_evt,
   input wire logic low_level_protocol_evt,
   input wire logic leader_bit_fault_evt,
   input wire logic irq_oe_n
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_st;
   logic rd_ctl;
   assign rd_st = pready && !pwrite && paddr == deirq_addr_status;
   assign rd_ctl = pready && !pwrite && paddr == deirq_addr_ctrl;
   chk_float_at_reset: assert property ($rose(presetn) |-> irq_oe_n) else $error("pin driven");
   chk_enable_drives: assert property (rd_ctl |-> prdata[0] == !irq_oe_n) else $error("pin enable");
   chk_sync_sets: assert property (rd_st && $past(sync_fault_evt, 3) |-> prdata[7]) else $error("bit 7");
   chk_checksum_sets: assert property (rd_st && $past(checksum_fault_evt, 3) |-> prdata[6]) else $error("bit 6");
   chk_uncorr_sets: assert property (rd_st && $past(uncorrectable_header_evt, 3) |-> prdata[5]) else $error("bit 5");
   chk_corr_sets: assert property (rd_st && $past(corrected_header_evt, 3) |-> prdata[4]) else $error("bit 4");
   chk_llp_sets: assert property (rd_st && $past(low_level_protocol_evt, 3) |-> prdata[3]) else $error("bit 3");
   chk_leader_sets: assert property (rd_st && $past(leader_bit_fault_evt, 3) |-> prdata[2]) else $error("bit 2");
endmodule
bind deirq_top deirq_monitor i_mon (.pclk, .presetn, .pwrite, .pready, .paddr, .prdata, .sync_fault_evt,
   .checksum_fault_evt, .uncorrectable_header_evt, .corrected_header_evt, .low_level_protocol_evt,
   .leader_bit_fault_evt, .irq_oe_n);

// >>> verification/deirq_host.sv
// Purpose: host model, apb master and pin watcher
// Assumes: the pin has a pull-down
// Notes: waits on pready end only by the bench timeout
`timescale 1ns/1ps
module deirq_host
   import deirq_pkg::*;
(
   // clock and apb master
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [deirq_addr_w-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // interrupt pin
   input wire logic irq_out,
   input wire logic irq_oe_n,
   output logic irq_pin
);
   assign irq_pin = irq_oe_n ? 1'b0 : irq_out;
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   task automatic xfer(input logic w, input logic [deirq_addr_w-1:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      {psel, penable} <= 2'h0;
   endtask
endmodule

// >>> verification/testbench.sv
// Purpose: random and corner tests of the error interrupt unit
// Assumes: seed 66, floating pin reads low
// Notes: evt bits 5:0 feed status bits 7:2
`timescale 1ns/1ps
module testbench
   import deirq_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, irq_out, irq_oe_n, irq_pin, pll_locked;
   logic [deirq_addr_w-1:0] paddr;
   logic [31:0] pwdata, prdata, q, r;
   logic [5:0] evt, v;
   int errors = 0, samples_checked = 0, cycles = 0;
   deirq_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
      .pslverr(), .sync_fault_evt(evt[5]), .checksum_fault_evt(evt[4]), .uncorrectable_header_evt(evt[3]),
      .corrected_header_evt(evt[2]), .low_level_protocol_evt(evt[1]), .leader_bit_fault_evt(evt[0]),
      .pll_locked, .irq_out, .irq_oe_n);
   deirq_host i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .irq_out, .irq_oe_n,
      .irq_pin);
   function automatic logic pin_exp(logic [7:0] st, logic [7:0] m, logic c);
      return c & |(st & m);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [deirq_addr_w-1:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [deirq_addr_w-1:0] a, input logic [31:0] x);
      i_host.xfer(1'b0, a, 32'h0, q);
      check(q, x);
   endtask
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      void'($urandom(66));
      presetn = 1'b0;
      pll_locked = 1'b1;
      evt = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      check(irq_oe_n, 1'b1);
      rd(deirq_addr_mask, 32'h0);
      rd(deirq_addr_status, 32'h1);
      wr(deirq_addr_status, 32'h1);
      rd(deirq_addr_status, 32'h0);
      for (int i = 0; i < 12; i++) begin
         r = $urandom;
         v = (i < 6) ? 6'h1 << i : r[21:16];
         wr(deirq_addr_mask, r);
         rd(deirq_addr_mask, r & 32'hfd);
         wr(deirq_addr_ctrl, r >> 8);
         rd(deirq_addr_ctrl, r[8]);
         evt <= v;
         @(posedge pclk);
         evt <= '0;
         rd(deirq_addr_status, {v, 2'h0});
         wr(deirq_addr_status, 32'h0);
         rd(deirq_addr_status, {v, 2'h0});
         check(irq_pin, pin_exp({v, 2'h0}, r[7:0], r[8]));
         check(irq_oe_n, !r[8]);
         wr(deirq_addr_status, r >> 14);
         rd(deirq_addr_status, {v & ~r[21:16], 2'h0});
         wr(deirq_addr_status, 32'hff);
         repeat (2) @(posedge pclk);
         check(irq_pin, 1'b0);
      end
      pll_locked <= 1'b0;
      repeat (8) @(posedge pclk);
      pll_locked <= 1'b1;
      rd(deirq_addr_status, 32'h1);
      summarize();
   end
endmodule
